// *** core/sram_boundary_scan_tap.sv ***
// Purpose: test access port of the memory device plus pll lock timing
// Assumes: tck is a free clock only while the tester works; rst is on clk
// Notes: tck domain holds all scan state; clk domain holds the lock timer
//
// Contract
// - three, one, thirty-two and 109 bit registers
// - code 000 captures ring into chain
// - code 001 selects identification, memory untouched
// - code 010 captures, scans, outputs high impedance
// - code 100 captures and scans, memory untouched
// - code 111 selects bypass, memory untouched
// - pll follows rising edges of input clock
// - pll works down to 120 MHz
// - identification holds revision, type, vendor, one
`timescale 1ns/100ps

module sram_boundary_scan_tap
   import sram_tap_pkg::*;
#(
   parameter logic [2:0] ID_REVISION = 3'h0,       // arbitrary value
   parameter logic [16:0] ID_DEVICE = 17'h0_1234,  // arbitrary value
   parameter logic [10:0] ID_VENDOR = 11'h055      // arbitrary value
) (
   input wire logic clk,                     // core clock
   input wire logic rst,                     // synchronous, active high
   input wire logic tck,                     // test clock
   input wire logic tms,                     // test mode select
   input wire logic tdi,                     // serial test input
   output logic tdo,                         // serial test output
   output logic tdo_oe,                      // high while tdo is driven
   input wire logic [RING_W-1:0] ring_in,    // ball values seen by the ring
   output logic [RING_W-1:0] ring_out,       // values loaded by update-dr
   output logic ring_drive,                  // chain drives balls (extest)
   input wire logic pll_enable_pin,          // pll enable pin level
   input wire logic clk_stable,              // input clock judged stable
   output logic pll_locked,                  // lock time has elapsed
   output logic mem_out_hiz                  // memory output drivers off
);

   // ----------------------------------------------------------------
   // reset crossing into the test clock domain
   // ----------------------------------------------------------------
   logic rst_tck1_q;   // first stage, read only by second
   logic rst_tck2_q;   // reset as seen by tck logic

   // two stage synchroniser; tap also resets itself with tms high
   always_ff @(posedge tck) begin
      rst_tck1_q <= rst;
      rst_tck2_q <= rst_tck1_q;
   end

   // ----------------------------------------------------------------
   // ring input synchroniser
   // ----------------------------------------------------------------
   logic [RING_W-1:0] ring_s1_q;   // first stage
   logic [RING_W-1:0] ring_s2_q;   // value offered to capture

   // balls change on the memory clock, so they cross before capture
   always_ff @(posedge tck) begin
      ring_s1_q <= ring_in;
      ring_s2_q <= ring_s1_q;
   end

   // ----------------------------------------------------------------
   // tap controller
   // ----------------------------------------------------------------
   tap_state_e state_q;   // current tap state
   tap_state_e state_d;   // next tap state

   always_comb begin
      unique case (state_q)
         TAP_RESET: state_d = tms ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: state_d = tms ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: state_d = tms ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: state_d = tms ? TAP_UPD_DR : TAP_PAUSE_DR;
         TAP_PAUSE_DR: state_d = tms ? TAP_EX2_DR : TAP_PAUSE_DR;
         TAP_EX2_DR: state_d = tms ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: state_d = tms ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: state_d = tms ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: state_d = tms ? TAP_UPD_IR : TAP_PAUSE_IR;
         TAP_PAUSE_IR: state_d = tms ? TAP_EX2_IR : TAP_PAUSE_IR;
         TAP_EX2_IR: state_d = tms ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: state_d = tms ? TAP_SEL_DR : TAP_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge tck) begin
      if (rst_tck2_q) begin
         state_q <= TAP_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // true for every code that puts the boundary chain on the path
   function automatic logic bsr_selected(input logic [2:0] code);
      return (code == IR_EXTEST) || (code == IR_SAMPLE_Z) || (code == IR_SAMPLE);
   endfunction

   // identification word, assembled from its fields
   // field layout
   localparam logic [ID_W-1:0] ID_WORD = ({29'h0, ID_REVISION} << ID_REV_LSB)
      | ({15'h0, ID_DEVICE} << ID_DEV_LSB) | ({21'h0, ID_VENDOR} << ID_VEN_LSB)
      | {31'h0, ID_MARK};

   // ----------------------------------------------------------------
   // instruction, data registers and decoded controls
   // ----------------------------------------------------------------
   // register sizes
   logic [IR_W-1:0] ir_sh_q, ir_sh_d;       // instruction shift stage
   logic [IR_W-1:0] ir_q, ir_d;             // active instruction
   logic byp_q, byp_d;                      // bypass bit
   logic [ID_W-1:0] id_q, id_d;             // identification shift
   logic [BSR_W-1:0] bsr_q, bsr_d;          // boundary chain shift
   logic [RING_W-1:0] upd_q, upd_d;         // boundary update latches
   logic drive_q, drive_d;                  // chain owns the balls
   logic hiz_q, hiz_d;                      // memory outputs forced off

   // next values for all scan state
   always_comb begin
      ir_sh_d = ir_sh_q;
      ir_d = ir_q;
      byp_d = byp_q;
      id_d = id_q;
      bsr_d = bsr_q;
      upd_d = upd_q;
      unique case (state_q)
         TAP_RESET: begin
            ir_d = IR_RESET;
         end
         TAP_CAP_IR: begin
            ir_sh_d = IR_CAPTURE;
         end
         TAP_SH_IR: begin
            ir_sh_d = {tdi, ir_sh_q[IR_W-1:1]};
         end
         TAP_UPD_IR: begin
            ir_d = ir_sh_q;
         end
         TAP_CAP_DR: begin
            byp_d = 1'b0;
            id_d = ID_WORD;
            if (bsr_selected(ir_q)) begin
               bsr_d = {1'b0, ring_s2_q};
            end
         end
         TAP_SH_DR: begin
            byp_d = tdi;
            id_d = {tdi, id_q[ID_W-1:1]};
            if (bsr_selected(ir_q)) begin
               bsr_d = {tdi, bsr_q[BSR_W-1:1]};
            end
         end
         TAP_UPD_DR: begin
            // preload values reach the update latches
            if (bsr_selected(ir_q)) begin
               upd_d = bsr_q[RING_W-1:0];
            end
         end
         default: begin
            // remaining states hold every register
         end
      endcase
      drive_d = (ir_d == IR_EXTEST);
      hiz_d = (ir_d == IR_SAMPLE_Z);
   end

   // register stage for scan state
   always_ff @(posedge tck) begin
      if (rst_tck2_q) begin
         ir_sh_q <= IR_RESET;
         ir_q <= IR_RESET;
         byp_q <= 1'b0;
         id_q <= '0;
         bsr_q <= '0;
         upd_q <= '0;
         drive_q <= 1'b0;
         hiz_q <= 1'b0;
      end else begin
         ir_sh_q <= ir_sh_d;
         ir_q <= ir_d;
         byp_q <= byp_d;
         id_q <= id_d;
         bsr_q <= bsr_d;
         upd_q <= upd_d;
         drive_q <= drive_d;
         hiz_q <= hiz_d;
      end
   end

   assign ring_out = upd_q;
   assign ring_drive = drive_q;

   // ----------------------------------------------------------------
   // serial output on the falling test clock
   // ----------------------------------------------------------------
   logic tdo_q, tdo_d;        // registered serial output
   logic tdo_oe_q, tdo_oe_d;  // registered output enable

   // path select; reserved codes fall to bypass so tdo stays defined
   always_comb begin
      tdo_d = 1'b0;
      tdo_oe_d = 1'b0;
      if (state_q == TAP_SH_IR) begin
         tdo_d = ir_sh_q[0];
         tdo_oe_d = 1'b1;
      end else if (state_q == TAP_SH_DR) begin
         tdo_oe_d = 1'b1;
         if (bsr_selected(ir_q)) begin
            tdo_d = bsr_q[0];
         end else if (ir_q == IR_IDCODE) begin
            tdo_d = id_q[0];
         end else begin
            tdo_d = byp_q;
         end
      end
   end

   always_ff @(negedge tck) begin
      if (rst_tck2_q) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else begin
         tdo_q <= tdo_d;
         tdo_oe_q <= tdo_oe_d;
      end
   end

   assign tdo = tdo_q;
   assign tdo_oe = tdo_oe_q;

   // ----------------------------------------------------------------
   // core clock side: crossings
   // ----------------------------------------------------------------
   logic hiz_s1_q, hiz_s2_q;   // high impedance level into clk
   logic en_s1_q, en_s2_q;     // pll enable pin synchroniser
   logic stb_s1_q, stb_s2_q;   // clock stable synchroniser

   // plain two flop crossings, all levels
   always_ff @(posedge clk) begin
      hiz_s1_q <= hiz_q;
      hiz_s2_q <= hiz_s1_q;
      en_s1_q <= pll_enable_pin;
      en_s2_q <= en_s1_q;
      stb_s1_q <= clk_stable;
      stb_s2_q <= stb_s1_q;
   end

   // ----------------------------------------------------------------
   // pll lock timer
   // ----------------------------------------------------------------
   localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(PLL_LOCK_CYCLES - 1);
   localparam logic [LOCK_CNT_W-1:0] LOCK_ONE = LOCK_CNT_W'(1);

   logic [LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d;   // stable cycles seen
   logic locked_q, locked_d;                         // lock reported
   logic hiz_out_q, hiz_out_d;                       // registered hiz output

   // timer assumes input clock at least PLL_MIN_FREQ_MHZ
   always_comb begin
      lock_cnt_d = lock_cnt_q;
      locked_d = locked_q;
      hiz_out_d = hiz_s2_q;
      if (!en_s2_q || !stb_s2_q) begin
         // any gap restarts the lock wait
         lock_cnt_d = '0;
         locked_d = 1'b0;
      end else if (lock_cnt_q == LOCK_LAST) begin
         locked_d = 1'b1;
      end else begin
         lock_cnt_d = lock_cnt_q + LOCK_ONE;
      end
   end

   // lock timer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         lock_cnt_q <= '0;
         locked_q <= 1'b0;
         hiz_out_q <= 1'b0;
      end else begin
         lock_cnt_q <= lock_cnt_d;
         locked_q <= locked_d;
         hiz_out_q <= hiz_out_d;
      end
   end

   assign pll_locked = locked_q;
   assign mem_out_hiz = hiz_out_q;

endmodule

// *** core/sram_tap_pkg.sv ***
// Purpose: shared constants and types for the memory test access port
// Assumes: 100 MHz core clock, test clock unrelated in phase
// Notes: identification fields are parameters of the top module
package sram_tap_pkg;

   // ----------------------------------------------------------------
   // scan register sizes
   // ----------------------------------------------------------------
   localparam int IR_W = 3;            // instruction register length
   localparam int ID_W = 32;           // identification register length
   localparam int BSR_W = 109;         // boundary chain length
   localparam int RING_W = 108;        // cells tied to balls, last cell is internal
   localparam int BSR_LAST = 108;      // index of the internal far-end cell

   // ----------------------------------------------------------------
   // instruction codes
   // ----------------------------------------------------------------
   localparam logic [2:0] IR_EXTEST = 3'h0;     // capture ring, drive outputs
   localparam logic [2:0] IR_IDCODE = 3'h1;     // identification register
   localparam logic [2:0] IR_SAMPLE_Z = 3'h2;   // capture ring, outputs high impedance
   localparam logic [2:0] IR_SAMPLE = 3'h4;     // capture ring, memory unaffected
   localparam logic [2:0] IR_BYPASS = 3'h7;     // single bit bypass
   localparam logic [2:0] IR_CAPTURE = 3'h1;    // pattern loaded in capture-ir
   localparam logic [2:0] IR_RESET = 3'h1;      // instruction after test logic reset

   // ----------------------------------------------------------------
   // identification field layout
   // ----------------------------------------------------------------
   localparam int ID_REV_LSB = 29;     // revision, bits 31:29
   localparam int ID_DEV_LSB = 12;     // device type, bits 28:12
   localparam int ID_VEN_LSB = 1;      // vendor, bits 11:1
   localparam logic ID_MARK = 1'b1;    // bit 0 always one

   // ----------------------------------------------------------------
   // pll lock timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;          // core clock period
   localparam int PLL_LOCK_TIME_US = 20;       // stable enable and clock needed
   localparam int PLL_MIN_FREQ_MHZ = 120;      // lowest input clock the pll accepts
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOCK_CNT_W = 11;             // holds PLL_LOCK_CYCLES - 1

   // ----------------------------------------------------------------
   // tap controller states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      TAP_RESET = 4'hF,
      TAP_IDLE = 4'hC,
      TAP_SEL_DR = 4'h7,
      TAP_CAP_DR = 4'h6,
      TAP_SH_DR = 4'h2,
      TAP_EX1_DR = 4'h1,
      TAP_PAUSE_DR = 4'h3,
      TAP_EX2_DR = 4'h0,
      TAP_UPD_DR = 4'h5,
      TAP_SEL_IR = 4'h4,
      TAP_CAP_IR = 4'hE,
      TAP_SH_IR = 4'hA,
      TAP_EX1_IR = 4'h9,
      TAP_PAUSE_IR = 4'hB,
      TAP_EX2_IR = 4'h8,
      TAP_UPD_IR = 4'hD
   } tap_state_e;

endpackage

// *** dv/sram_boundary_scan_tap_assertions.sv ***
// Purpose: concurrent checks on the test port and lock timer
// Assumes: tester moves tms right after tck falls
// Notes: bound to the top module
`timescale 1ns/100ps

module tap_checker
   import sram_tap_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdo,
   input wire logic tdo_oe,
   input wire logic [RING_W-1:0] ring_out,
   input wire logic ring_drive,
   input wire logic pll_enable_pin,
   input wire logic clk_stable,
   input wire logic pll_locked,
   input wire logic mem_out_hiz
);
   logic [11:0] cnt_d; // cycles with enable and stable clock high
   logic [11:0] cnt_q;

   // saturate so long holds never wrap
   always_comb begin
      cnt_d = 12'h000;
      if (pll_enable_pin && clk_stable) begin
         cnt_d = (cnt_q == 12'hfff) ? cnt_q : cnt_q + 12'h001;
      end
   end

   // register the count
   always_ff @(posedge clk) begin
      cnt_q <= rst ? 12'h000 : cnt_d;
   end

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   tdo_idle_a: assert property (@(negedge tck) disable iff (rst) !tdo_oe |-> !tdo)
      else $error("tdo high outside shift");
   oe_rise_a: assert property (@(negedge tck) disable iff (rst) $rose(tdo_oe) |-> !$past(tms))
      else $error("shift entered with tms high");
   oe_fall_a: assert property (@(negedge tck) disable iff (rst) $fell(tdo_oe) |-> $past(tms))
      else $error("shift left with tms low");
   ring_upd_a: assert property (@(posedge tck) disable iff (rst)
      $changed(ring_out) |-> $past(tms, 2) && $past(tms, 3))
      else $error("ring out moved outside update");
   drive_upd_a: assert property (@(posedge tck) disable iff (rst)
      $changed(ring_drive) |-> $past(tms, 2) && $past(tms, 3))
      else $error("ring drive moved outside update");
   hiz_excl_a: assert property (@(posedge clk) disable iff (rst) $rose(mem_out_hiz) |-> !ring_drive)
      else $error("outputs off while ring drives");
   lock_time_a: assert property (@(posedge clk) disable iff (rst)
      $rose(pll_locked) |-> cnt_q >= 12'h07d0 && cnt_q <= 12'h07d8)
      else $error("lock after wrong hold time");
   lock_hold_a: assert property (@(posedge clk) disable iff (rst) cnt_q == 12'h07da |-> pll_locked)
      else $error("no lock after full hold");
   lock_drop_a: assert property (@(posedge clk) disable iff (rst)
      $fell(pll_enable_pin) |-> ##[1:4] !pll_locked)
      else $error("lock kept after enable low");
endmodule

bind sram_boundary_scan_tap tap_checker u_tap_checker (
   .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe(tdo_oe), .ring_out(ring_out),
   .ring_drive(ring_drive), .pll_enable_pin(pll_enable_pin), .clk_stable(clk_stable),
   .pll_locked(pll_locked), .mem_out_hiz(mem_out_hiz)
);

// *** dv/sram_boundary_scan_tap_tb.sv ***
// Purpose: self-checking bench for the memory test port
// Assumes: tester model owns tck, tms and tdi
// Notes: lock timing runs at full length
`timescale 1ns/100ps

module sram_boundary_scan_tap_tb
   import sram_tap_pkg::*;
;
   localparam logic [2:0] REV = 3'h5; // arbitrary value
   localparam logic [16:0] DEV = 17'h1_5a3c; // arbitrary value
   localparam logic [10:0] VEN = 11'h02c7; // arbitrary value
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pll_enable_pin = 1'b0;
   logic clk_stable = 1'b0;
   logic tck, tms, tdi, tdo, tdo_oe, ring_drive, pll_locked, mem_out_hiz;
   logic [RING_W-1:0] ring_in = '0;
   logic [RING_W-1:0] ring_out;
   logic [127:0] din, dout;
   int seed = 75;
   int miscompares = 0;
   int checks = 0;
   logic [2:0] codes [5] = '{IR_BYPASS, IR_EXTEST, IR_SAMPLE_Z, IR_IDCODE, IR_SAMPLE};

   always #5 clk = ~clk;

   sram_boundary_scan_tap #(.ID_REVISION(REV), .ID_DEVICE(DEV), .ID_VENDOR(VEN)) DUT (
      .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in),
      .ring_out(ring_out), .ring_drive(ring_drive), .pll_enable_pin(pll_enable_pin), .clk_stable(clk_stable),
      .pll_locked(pll_locked), .mem_out_hiz(mem_out_hiz)
   );
   tap_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

   task automatic cmp(input logic [127:0] got, input logic [127:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   // path length per instruction
   function automatic int chain_len(input logic [2:0] code);
      if (code == IR_IDCODE) begin
         return ID_W;
      end
      return (code == IR_BYPASS) ? 1 : BSR_W;
   endfunction

   // capture, then the first eight bits fed in; far cell reads zero
   function automatic logic [127:0] exp_out(input logic [2:0] code, input logic [127:0] d);
      logic [127:0] e;
      e = (code == IR_BYPASS) ? 128'h0 : {20'h0, ring_in};
      if (code == IR_IDCODE) begin
         e = {96'h0, REV, DEV, VEN, 1'b1};
      end
      for (int i = 0; i < 8; i++) begin
         e[chain_len(code) + i] = d[i];
      end
      return e;
   endfunction

   // scan the path, then see what update left on the ring
   task automatic dr_check(input logic [2:0] code);
      logic [RING_W-1:0] prev;
      prev = ring_out;
      din = {$random(seed), $random(seed), $random(seed), $random(seed)};
      tester.scan(1'b0, chain_len(code) + 8, din, dout);
      cmp(dout, exp_out(code, din), "scan out");
      if (chain_len(code) == BSR_W) begin
         prev = din[8 +: RING_W];
      end
      cmp(128'(ring_out), 128'(prev), "ring out");
   endtask

   // host sets enable and clock state, waits, then looks at lock
   task automatic pll_case(input logic en, input logic st, input int w, input logic exp);
      @(posedge clk);
      pll_enable_pin <= en;
      clk_stable <= st;
      repeat (w) @(posedge clk);
      // look half a cycle on, so the flop launched at this edge has settled
      @(negedge clk);
      cmp(128'(pll_locked), 128'(exp), "lock");
   endtask

   task automatic end_of_test();
      if (miscompares == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (60000) @(posedge clk);
      miscompares++;
      end_of_test();
   end

   initial begin
      // tck must run while reset is high so its side clears
      tester.tlr();
      @(posedge clk);
      rst <= 1'b0;
      tester.tlr();
      dr_check(IR_IDCODE);
      foreach (codes[k]) begin
         @(posedge clk);
         ring_in <= RING_W'({$random(seed), $random(seed), $random(seed), $random(seed)});
         tester.scan(1'b1, IR_W, 128'(codes[k]), dout);
         cmp(dout, 128'h1, "ir capture");
         repeat (8) @(posedge clk);
         cmp(128'(ring_drive), 128'(codes[k] == IR_EXTEST), "drive");
         cmp(128'(mem_out_hiz), 128'(codes[k] == IR_SAMPLE_Z), "hiz");
         dr_check(codes[k]);
      end
      tester.tlr();
      dr_check(IR_IDCODE);
      pll_case(1'b1, 1'b1, PLL_LOCK_CYCLES - 10, 1'b0);
      pll_case(1'b1, 1'b1, 20, 1'b1);
      pll_case(1'b1, 1'b0, 6, 1'b0);
      pll_case(1'b1, 1'b1, PLL_LOCK_CYCLES + 20, 1'b1);
      pll_case(1'b0, 1'b1, 6, 1'b0);
      end_of_test();
   end
endmodule

// *** dv/tap_tester.sv ***
// Purpose: scan controller model driving the test port
// Assumes: tck stands low between calls, 160 ns period within them
// Notes: tdi toggles outside shift so stale data never looks valid
`timescale 1ns/100ps

module tap_tester (
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   // idle levels before the first frame
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #80 tck = 1'b1;
      o = tdo;
      #80 tck = 1'b0;
   endtask

   // small offset keeps tck edges off the core clock edges
   task automatic walk(input logic [7:0] seq, input int n);
      logic o;
      #3;
      for (int i = 0; i < n; i++) begin
         step(seq[i], ~tdi, o);
      end
   endtask

   task automatic tlr();
      walk(8'h1f, 6);
   endtask

   task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
      logic o;
      dout = '0;
      walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      walk(8'h01, 2);
   endtask
endmodule
